/* design/usmis_pkg.sv */
/*
  Shared constants of the serial channel mode, mask and status block.
  Assumes a 32-bit register bus with one aligned word per register.
*/
`default_nettype none
package usmis_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_MODE       = 8'h04;
  localparam logic [7:0] OFF_IRQ_SET    = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLR    = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATE  = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;
  localparam logic [7:0] OFF_RX_HOLD    = 8'h18;
  localparam logic [7:0] OFF_TX_HOLD    = 8'h1c;
  localparam logic [7:0] OFF_IDLE_LIMIT = 8'h24;
  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [16:0] RST_LIMIT = 17'h0_0000;
  localparam logic [8:0]  RST_CHAR  = 9'h000;
  // Control command bits
  localparam int CMD_RX_ON     = 4;
  localparam int CMD_RX_OFF    = 5;
  localparam int CMD_TX_ON     = 6;
  localparam int CMD_TX_OFF    = 7;
  localparam int CMD_CLR_FLAGS = 8;
  localparam int CMD_BRK_BEGIN = 9;
  localparam int CMD_TO_RESTART = 11;
  localparam int CMD_CLR_NACK  = 14;
  localparam int CMD_TO_REARM  = 15;
  // Mode register fields
  localparam int MODE_LO   = 0;
  localparam int CLKS_LO   = 4;
  localparam int CHAR_LENGTH_FIELD_LO   = 6;
  localparam int SYNC_BIT  = 8;
  localparam int PAR_LO    = 9;
  localparam int SPI_IDLE_LEVEL_BIT  = 16;
  localparam logic [31:0] MODE_WR_MASK = 32'h001f_ffff;
  localparam logic [3:0] OPM_NORMAL    = 4'h0;
  localparam logic [3:0] OPM_HANDSHAKE = 4'h2;
  localparam logic [3:0] OPM_LIN_MST   = 4'ha;
  localparam logic [3:0] OPM_LIN_SLV   = 4'hb;
  localparam logic [3:0] OPM_SPI_MST   = 4'he;
  localparam logic [3:0] OPM_SPI_SLV   = 4'hf;
  localparam logic [1:0] PAR_MULTIDROP = 2'h3;
  // Status bit positions
  localparam int ST_RX_AVAIL   = 0;
  localparam int ST_TX_FREE    = 1;
  localparam int ST_BREAK      = 2;
  localparam int ST_OVERRUN    = 5;
  localparam int ST_FRAME      = 6;
  localparam int ST_PARITY     = 7;
  localparam int ST_TIMEOUT    = 8;
  localparam int ST_TX_DRAINED = 9;
  localparam int ST_REPEAT     = 10;
  localparam int ST_DMA_FULL   = 12;
  localparam int ST_NACK       = 13;
  localparam int ST_LIN_ID     = 14;
  localparam int ST_LIN_DONE   = 15;
  localparam int ST_CTS_CHANGE = 19;
  localparam int ST_CTS        = 23;
  localparam int ST_LIN_BIT    = 25;
  localparam int ST_LIN_SYNC   = 26;
  localparam int ST_LIN_IDPAR  = 27;
  localparam int ST_LIN_SUM    = 28;
  localparam int ST_LIN_NOREP  = 29;
  localparam logic [31:0] IRQ_SRC_MASK  = 32'h3e08_f7e7;
  localparam logic [31:0] CLR_FLAGS_SET = 32'h3e00_c4e4;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* design/usmis_flag_if.sv */
/*
  Carrier between the top and its sticky flag bank.
  Assumes both ends run on the block clock.
*/
`default_nettype none
interface usmis_flag_if;
  logic [31:0] set;
  logic [31:0] clr;
  logic [31:0] q;
  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface
`default_nettype wire

/* design/usmis_sync2.sv */
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes the input changes slower than the clock.
*/
`default_nettype none
module usmis_sync2 (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST_B,
  // Level
  input  wire logic d,
  output var  logic q
);
  logic meta;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* design/usmis_flag_bank.sv */
/*
  Bank of sticky flags, one flop per bit; set wins over clear.
  Assumes set and clear are single-cycle terms on the block clock.
*/
`default_nettype none
module usmis_flag_bank (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST_B,
  // Flags
  usmis_flag_if.bank fl
);
  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_bit
      always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          fl.q[i] <= 1'b0;
        end else if (fl.set[i]) begin
          fl.q[i] <= 1'b1;
        end else if (fl.clr[i]) begin
          fl.q[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* design/usmis_top.sv */
/*
  Mode, interrupt mask and channel status block of a serial channel,
  with an AXI4-Lite register slave.
  Assumes the receiver, transmitter, LIN and SPI engines sit outside and
  report events as one-cycle pulses on the block clock; CTS is a pin.
*/
// Our own choice: the AXI4-Lite register port.
`default_nettype none
module usmis_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output var  logic        AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output var  logic        WREADY,
  // AXI4-Lite write response
  output var  logic [1:0]  BRESP,
  output var  logic        BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output var  logic        ARREADY,
  output var  logic [31:0] RDATA,
  output var  logic [1:0]  RRESP,
  output var  logic        RVALID,
  input  wire logic        RREADY,
  // Receiver events
  input  wire logic        RX_CHAR_DONE,
  input  wire logic [8:0]  RX_CHAR,
  input  wire logic        RX_BUSY,
  input  wire logic        RX_PARITY_ERR,
  input  wire logic        RX_PARITY_ONE,
  input  wire logic        RX_STOP_LOW,
  input  wire logic        RX_OVERRUN,
  input  wire logic        RX_BREAK_EDGE,
  input  wire logic        RX_TIMEOUT,
  input  wire logic        NACK_SEEN,
  input  wire logic        REPEAT_LIMIT,
  input  wire logic        SPI_UNDERRUN,
  // LIN events
  input  wire logic        LIN_NO_REPLY,
  input  wire logic        LIN_SUM_ERR,
  input  wire logic        LIN_ID_PARITY,
  input  wire logic        LIN_SYNC_ERR,
  input  wire logic        LIN_BIT_ERR,
  input  wire logic        LIN_DONE,
  input  wire logic        LIN_IDENT,
  // Transmitter and DMA
  input  wire logic        TX_TAKE,
  input  wire logic        TX_SHIFT_EMPTY,
  input  wire logic        BREAK_STARTED,
  input  wire logic        DMA_BUF_FULL,
  // Pins
  input  wire logic        CTS_PIN,
  // Mode outputs
  output var  logic        SYNC_FRAMING,
  output var  logic        SPI_ACTIVE,
  output var  logic        SPI_SLAVE,
  output var  logic        SPI_PHASE,
  output var  logic        SPI_IDLE_LEVEL,
  output var  logic [3:0]  CHAR_BITS,
  output var  logic [1:0]  BAUD_SOURCE,
  output var  logic [3:0]  OP_MODE,
  output var  logic        HANDSHAKE,
  output var  logic        LIN_MASTER,
  output var  logic        LIN_SLAVE,
  // Transmit data and enables
  output var  logic [8:0]  TX_CHAR,
  output var  logic        TX_CHAR_VALID,
  output var  logic        BREAK_REQ,
  output var  logic        TX_ENABLED,
  output var  logic        RX_ENABLED,
  output var  logic        TIMEOUT_RESTART,
  // Interrupt
  output var  logic        IRQ
);
  function automatic logic is_spi(input logic [3:0] m);
    is_spi = (m == usmis_pkg::OPM_SPI_MST) || (m == usmis_pkg::OPM_SPI_SLV);
  endfunction

  usmis_flag_if fl ();

  logic [31:0] mode;
  logic [31:0] mask;
  logic [16:0] idle_limit;
  logic [8:0]  rx_hold;
  logic [8:0]  tx_hold;
  logic        tx_full;
  logic        brk_pend;
  logic        tx_en;
  logic        rx_en;
  logic        rx_cut;
  logic        cts_q;
  logic        cts_d;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_fire;
  logic        ctrl_wr;
  logic        rd_fire;
  logic        rd_status;
  logic        rd_rxhold;
  logic [31:0] status;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_hit;
  logic        rx_enable_now;
  logic [3:0]  opm;

  usmis_sync2 u_cts_sync (
    .CLK   (CLK),
    .RST_B (RST_B),
    .d     (CTS_PIN),
    .q     (cts_q)
  );

  usmis_flag_bank u_flags (
    .CLK   (CLK),
    .RST_B (RST_B),
    .fl    (fl)
  );

  assign opm = mode[usmis_pkg::MODE_LO +: 4];

  // Bus write handshake
  assign wr_fire = aw_held && w_held && !BVALID;
  assign ctrl_wr = wr_fire && (aw_addr == usmis_pkg::OFF_CTRL);
  assign rd_fire = ARVALID && ARREADY;
  assign rd_status = rd_fire && (ARADDR == usmis_pkg::OFF_STATUS);
  assign rd_rxhold = rd_fire && (ARADDR == usmis_pkg::OFF_RX_HOLD);
  assign rx_enable_now = ctrl_wr && w_data[usmis_pkg::CMD_RX_ON] && !w_data[usmis_pkg::CMD_RX_OFF];

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= usmis_pkg::RST_WORD;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= usmis_pkg::RESP_OKAY;
    end else begin
      AWREADY <= !aw_held && !BVALID && !(AWVALID && AWREADY);
      WREADY  <= !w_held && !BVALID && !(WVALID && WREADY);
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= wr_hit ? usmis_pkg::RESP_OKAY : usmis_pkg::RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      usmis_pkg::OFF_CTRL, usmis_pkg::OFF_MODE, usmis_pkg::OFF_IRQ_SET,
      usmis_pkg::OFF_IRQ_CLR, usmis_pkg::OFF_TX_HOLD, usmis_pkg::OFF_IDLE_LIMIT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Mode and time-out limit registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode       <= usmis_pkg::RST_WORD;
      idle_limit <= usmis_pkg::RST_LIMIT;
    end else if (wr_fire && (aw_addr == usmis_pkg::OFF_MODE)) begin
      mode <= w_data & usmis_pkg::MODE_WR_MASK;
    end else if (wr_fire && (aw_addr == usmis_pkg::OFF_IDLE_LIMIT)) begin
      idle_limit <= w_data[16:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask <= usmis_pkg::RST_WORD;
    end else if (wr_fire && (aw_addr == usmis_pkg::OFF_IRQ_SET)) begin
      mask <= mask | (w_data & usmis_pkg::IRQ_SRC_MASK);
    end else if (wr_fire && (aw_addr == usmis_pkg::OFF_IRQ_CLR)) begin
      mask <= mask & ~w_data;
    end
  end

  // Transmitter and receiver enables
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_en  <= 1'b0;
      rx_en  <= 1'b0;
      rx_cut <= 1'b0;
    end else if (ctrl_wr) begin
      if (w_data[usmis_pkg::CMD_TX_OFF]) begin
        tx_en <= 1'b0;
      end else if (w_data[usmis_pkg::CMD_TX_ON]) begin
        tx_en <= 1'b1;
      end
      if (w_data[usmis_pkg::CMD_RX_OFF]) begin
        rx_en  <= 1'b0;
        rx_cut <= rx_en && RX_BUSY;
      end else if (w_data[usmis_pkg::CMD_RX_ON]) begin
        rx_en  <= 1'b1;
        rx_cut <= 1'b0;
      end
    end
  end

  // Holding registers and break request
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_hold  <= usmis_pkg::RST_CHAR;
      tx_full  <= 1'b0;
      brk_pend <= 1'b0;
      rx_hold  <= usmis_pkg::RST_CHAR;
    end else begin
      if (wr_fire && (aw_addr == usmis_pkg::OFF_TX_HOLD)) begin
        tx_hold <= w_data[8:0];
        tx_full <= 1'b1;
      end else if (TX_TAKE) begin
        tx_full <= 1'b0;
      end
      if (ctrl_wr && w_data[usmis_pkg::CMD_BRK_BEGIN]) begin
        brk_pend <= 1'b1;
      end else if (BREAK_STARTED) begin
        brk_pend <= 1'b0;
      end
      if (RX_CHAR_DONE) begin
        rx_hold <= RX_CHAR;
      end
    end
  end

  // Sticky flag sources
  always_comb begin
    fl.set = usmis_pkg::RST_WORD;
    fl.set[usmis_pkg::ST_LIN_NOREP] = LIN_NO_REPLY;
    fl.set[usmis_pkg::ST_LIN_SUM]   = LIN_SUM_ERR;
    fl.set[usmis_pkg::ST_LIN_IDPAR] = LIN_ID_PARITY;
    fl.set[usmis_pkg::ST_LIN_BIT]   = LIN_BIT_ERR;
    fl.set[usmis_pkg::ST_LIN_SYNC]  = LIN_SYNC_ERR && (opm == usmis_pkg::OPM_LIN_SLV);
    fl.set[usmis_pkg::ST_CTS_CHANGE] = cts_q != cts_d;
    fl.set[usmis_pkg::ST_LIN_DONE]  = LIN_DONE;
    fl.set[usmis_pkg::ST_LIN_ID]    = LIN_IDENT;
    fl.set[usmis_pkg::ST_NACK]      = NACK_SEEN;
    fl.set[usmis_pkg::ST_REPEAT]    = (opm == usmis_pkg::OPM_SPI_SLV) ?
                                      SPI_UNDERRUN : REPEAT_LIMIT;
    fl.set[usmis_pkg::ST_TIMEOUT]   = RX_TIMEOUT && (idle_limit != 17'h0_0000);
    fl.set[usmis_pkg::ST_PARITY]    =
      (mode[usmis_pkg::PAR_LO + 1 +: 2] == usmis_pkg::PAR_MULTIDROP) ?
      RX_PARITY_ONE : RX_PARITY_ERR;
    fl.set[usmis_pkg::ST_FRAME]     = RX_STOP_LOW;
    fl.set[usmis_pkg::ST_OVERRUN]   = RX_OVERRUN;
    fl.set[usmis_pkg::ST_BREAK]     = RX_BREAK_EDGE;
    fl.set[usmis_pkg::ST_RX_AVAIL]  = RX_CHAR_DONE || (rx_enable_now && rx_cut);
  end

  // Sticky flag clears
  always_comb begin
    fl.clr = usmis_pkg::RST_WORD;
    if (ctrl_wr && w_data[usmis_pkg::CMD_CLR_FLAGS]) begin
      fl.clr = usmis_pkg::CLR_FLAGS_SET;
    end
    fl.clr[usmis_pkg::ST_NACK] = ctrl_wr && w_data[usmis_pkg::CMD_CLR_NACK];
    fl.clr[usmis_pkg::ST_TIMEOUT] = ctrl_wr && (w_data[usmis_pkg::CMD_TO_RESTART] ||
                                                w_data[usmis_pkg::CMD_TO_REARM]);
    fl.clr[usmis_pkg::ST_CTS_CHANGE] = rd_status;
    fl.clr[usmis_pkg::ST_RX_AVAIL] = rd_rxhold;
  end

  // Status word
  always_comb begin
    status = fl.q & usmis_pkg::IRQ_SRC_MASK;
    status[usmis_pkg::ST_CTS]        = cts_q;
    status[usmis_pkg::ST_DMA_FULL]   = DMA_BUF_FULL;
    status[usmis_pkg::ST_TX_DRAINED] = tx_en && !tx_full && TX_SHIFT_EMPTY;
    status[usmis_pkg::ST_TIMEOUT]    = fl.q[usmis_pkg::ST_TIMEOUT] &&
                                       (idle_limit != 17'h0_0000);
    status[usmis_pkg::ST_TX_FREE]    = tx_en && !tx_full && !brk_pend;
    status[usmis_pkg::ST_RX_AVAIL]   = fl.q[usmis_pkg::ST_RX_AVAIL] && rx_en;
  end

  always_comb begin
    rd_hit  = 1'b1;
    case (ARADDR)
      usmis_pkg::OFF_MODE:       rd_word = mode;
      usmis_pkg::OFF_IRQ_STATE:  rd_word = mask;
      usmis_pkg::OFF_STATUS:     rd_word = status;
      usmis_pkg::OFF_RX_HOLD:    rd_word = {23'h00_0000, rx_hold};
      usmis_pkg::OFF_IDLE_LIMIT: rd_word = {15'h0000, idle_limit};
      usmis_pkg::OFF_CTRL, usmis_pkg::OFF_IRQ_SET,
      usmis_pkg::OFF_IRQ_CLR, usmis_pkg::OFF_TX_HOLD: rd_word = usmis_pkg::RST_WORD;
      default: begin
        rd_word = usmis_pkg::RST_WORD;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // Bus read channel
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= usmis_pkg::RST_WORD;
      RRESP   <= usmis_pkg::RESP_OKAY;
    end else begin
      ARREADY <= !RVALID && !rd_fire;
      if (rd_fire) begin
        RVALID <= 1'b1;
        RDATA  <= rd_word;
        RRESP  <= rd_hit ? usmis_pkg::RESP_OKAY : usmis_pkg::RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // CTS edge memory and interrupt
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cts_d <= 1'b0;
      IRQ   <= 1'b0;
    end else begin
      cts_d <= cts_q;
      IRQ   <= |(status & mask);
    end
  end

  // Registered mode decode
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      SYNC_FRAMING   <= 1'b0;
      SPI_ACTIVE     <= 1'b0;
      SPI_SLAVE      <= 1'b0;
      SPI_PHASE      <= 1'b0;
      SPI_IDLE_LEVEL <= 1'b0;
      CHAR_BITS      <= 4'h5;
      BAUD_SOURCE    <= 2'h0;
      OP_MODE        <= usmis_pkg::OPM_NORMAL;
      HANDSHAKE      <= 1'b0;
      LIN_MASTER     <= 1'b0;
      LIN_SLAVE      <= 1'b0;
    end else begin
      SYNC_FRAMING   <= !is_spi(opm) && mode[usmis_pkg::SYNC_BIT];
      SPI_ACTIVE     <= is_spi(opm);
      SPI_SLAVE      <= opm == usmis_pkg::OPM_SPI_SLV;
      SPI_PHASE      <= is_spi(opm) && mode[usmis_pkg::SYNC_BIT];
      SPI_IDLE_LEVEL <= mode[usmis_pkg::SPI_IDLE_LEVEL_BIT];
      CHAR_BITS      <= 4'h5 + {2'h0, mode[usmis_pkg::CHAR_LENGTH_FIELD_LO +: 2]};
      BAUD_SOURCE    <= mode[usmis_pkg::CLKS_LO +: 2];
      OP_MODE        <= opm;
      HANDSHAKE      <= opm == usmis_pkg::OPM_HANDSHAKE;
      LIN_MASTER     <= opm == usmis_pkg::OPM_LIN_MST;
      LIN_SLAVE      <= opm == usmis_pkg::OPM_LIN_SLV;
    end
  end

  // Registered transmit side outputs, enables and time-out restart
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      TX_CHAR         <= usmis_pkg::RST_CHAR;
      TX_CHAR_VALID   <= 1'b0;
      BREAK_REQ       <= 1'b0;
      TX_ENABLED      <= 1'b0;
      RX_ENABLED      <= 1'b0;
      TIMEOUT_RESTART <= 1'b0;
    end else begin
      TX_CHAR         <= tx_hold;
      TX_CHAR_VALID   <= tx_full && !TX_TAKE;
      BREAK_REQ       <= brk_pend && !BREAK_STARTED;
      TX_ENABLED      <= tx_en;
      RX_ENABLED      <= rx_en;
      TIMEOUT_RESTART <= ctrl_wr && w_data[usmis_pkg::CMD_TO_RESTART];
    end
  end
endmodule
`default_nettype wire

/* tb/usmis_properties.sv */
/*
  Concurrent checks on the ports of the status block.
  Assumes it is bound to usmis_top.
*/
`default_nettype none
module usmis_properties (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST_B,
  // Register bus
  input wire logic       AWVALID, AWREADY, WVALID, WREADY,
  input wire logic       BVALID, ARVALID, ARREADY, RVALID,
  // Mode outputs and pulses
  input wire logic [3:0] OP_MODE, CHAR_BITS,
  input wire logic       SPI_ACTIVE, SPI_SLAVE, HANDSHAKE,
  input wire logic       LIN_MASTER, LIN_SLAVE, TIMEOUT_RESTART
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  a_char_range: assert property (CHAR_BITS inside {[4'h5:4'h8]})
    else $error("character length out of range");
  a_spi_decode: assert property (SPI_ACTIVE == (OP_MODE inside {4'he, 4'hf}))
    else $error("spi flag disagrees with mode");
  a_spi_slave: assert property (SPI_SLAVE == (OP_MODE == 4'hf))
    else $error("spi slave flag disagrees with mode");
  a_lin_nodes: assert property ({LIN_MASTER, LIN_SLAVE} ==
      {OP_MODE == 4'ha, OP_MODE == 4'hb})
    else $error("lin node flags disagree with mode");
  a_handshake_mode: assert property (HANDSHAKE == (OP_MODE == 4'h2))
    else $error("handshake flag disagrees with mode");
  a_restart_pulse: assert property (TIMEOUT_RESTART |=> !TIMEOUT_RESTART)
    else $error("restart longer than one cycle");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read response late");
endmodule

bind usmis_top usmis_properties u_usmis_properties (.*);
`default_nettype wire

/* tb/usmis_partner.sv */
/*
  Transmit shifter on the far side: takes a held character after a stall.
  Assumes the block clock and reset.
*/
`default_nettype none
module usmis_partner (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_B,
  // Stall before taking
  input  wire logic [3:0] stall,
  // Transmit handover
  input  wire logic       TX_CHAR_VALID,
  output var  logic       TX_TAKE,
  output var  logic       TX_SHIFT_EMPTY
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_cnt;
  logic [3:0] busy_cnt;

  // Take after stall, then shift for eight cycles
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_cnt <= 4'h0;
      busy_cnt <= 4'h0;
      TX_TAKE  <= 1'b0;
    end else begin
      TX_TAKE <= 1'b0;
      if (busy_cnt != 4'h0) begin
        busy_cnt <= busy_cnt - 4'h1;
      end else if (TX_CHAR_VALID && !TX_TAKE) begin
        if (wait_cnt == stall) begin
          TX_TAKE  <= 1'b1;
          busy_cnt <= 4'h8;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end

  assign TX_SHIFT_EMPTY = (busy_cnt == 4'h0);
endmodule
`default_nettype wire

/* tb/test_usart_mode_irq_status.sv */
/*
  Self-checking bench of the mode, mask and status block.
  Assumes package, design, checker and partner are compiled first.
*/
`default_nettype none
module test_usart_mode_irq_status;
  timeunit 1ns;
  timeprecision 100ps;
  // Bus
  logic        CLK, RST_B, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [3:0]  WSTRB, stall, CHAR_BITS, OP_MODE;
  logic [1:0]  BRESP, RRESP, rr, BAUD_SOURCE;
  // Events and levels
  logic [15:0] ev;
  logic [8:0]  RX_CHAR, TX_CHAR;
  logic        RX_CHAR_DONE, RX_BUSY, RX_PARITY_ERR, RX_PARITY_ONE, RX_STOP_LOW, RX_OVERRUN;
  logic        RX_BREAK_EDGE, RX_TIMEOUT, NACK_SEEN, REPEAT_LIMIT, SPI_UNDERRUN, LIN_NO_REPLY;
  logic        LIN_SUM_ERR, LIN_ID_PARITY, LIN_SYNC_ERR, LIN_BIT_ERR, LIN_DONE, LIN_IDENT;
  logic        TX_TAKE, TX_SHIFT_EMPTY, BREAK_STARTED, DMA_BUF_FULL, CTS_PIN;
  // Outputs
  logic        SYNC_FRAMING, SPI_ACTIVE, SPI_SLAVE, SPI_PHASE, SPI_IDLE_LEVEL, HANDSHAKE;
  logic        LIN_MASTER, LIN_SLAVE, TX_CHAR_VALID, BREAK_REQ, TX_ENABLED, RX_ENABLED;
  logic        TIMEOUT_RESTART, IRQ;
  int          fail_count, compares;
  // Event row: status bit, level after the clear command
  int          rows [13][2] = '{'{7,0}, '{6,0}, '{5,0}, '{2,0}, '{10,0}, '{29,0}, '{28,0},
                                '{27,0}, '{26,0}, '{25,0}, '{15,0}, '{14,0}, '{13,1}};

  assign {SPI_UNDERRUN, RX_CHAR_DONE, RX_TIMEOUT, NACK_SEEN, LIN_IDENT, LIN_DONE, LIN_BIT_ERR,
          LIN_SYNC_ERR, LIN_ID_PARITY, LIN_SUM_ERR, LIN_NO_REPLY, REPEAT_LIMIT, RX_BREAK_EDGE,
          RX_OVERRUN, RX_STOP_LOW, RX_PARITY_ERR} = ev;

  usmis_top u_usmis_top (.*);
  usmis_partner u_usmis_partner (.*);

  always #25 CLK = ~CLK;

  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tmo(input int n);
    if (n > 40) begin
      fail_count++;
      $display("ERROR bus answer expected 1 seen 0");
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    b = 1'b0;
    for (int n = 0; !b; n++) begin
      tmo(n);
      @(negedge CLK);
      aw = AWVALID & AWREADY;
      w = WVALID & WREADY;
      b = BVALID;
      rr = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    r = 1'b0;
    for (int n = 0; !r; n++) begin
      tmo(n);
      @(negedge CLK);
      ar = ARVALID & ARREADY;
      r = RVALID;
      rv = RDATA;
      rr = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rs;
    rd(usmis_pkg::OFF_STATUS);
  endtask

  task automatic cmd(input int b);
    wr(usmis_pkg::OFF_CTRL, 32'h1 << b);
  endtask

  task automatic cb(input string n, input int b, input logic e);
    chk(n, {31'h0, rv[b]}, {31'h0, e});
  endtask

  task automatic pulse(input int i);
    ev <= 16'h1 << i;
    @(posedge CLK);
    ev <= 16'h0;
    @(posedge CLK);
  endtask

  initial begin
    {CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA, ev, RX_CHAR,
     RX_BUSY, RX_PARITY_ONE, BREAK_STARTED, DMA_BUF_FULL, CTS_PIN, stall} = '0;
    WSTRB = 4'hf;
    repeat (20) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rs();
    chk("status reset", rv, 32'h0);
    rd(usmis_pkg::OFF_IRQ_STATE);
    chk("mask reset", rv, 32'h0);
    $display("test reset done");
    wr(usmis_pkg::OFF_MODE, 32'h0000_000b);
    foreach (rows[i]) begin
      pulse(i);
      rs();
      cb("flag set", rows[i][0], 1'b1);
      cmd(usmis_pkg::CMD_CLR_FLAGS);
      rs();
      cb("flag after clear", rows[i][0], rows[i][1] == 1);
    end
    cmd(usmis_pkg::CMD_CLR_NACK);
    rs();
    cb("nack cleared", 13, 1'b0);
    $display("test event rows done");
    wr(usmis_pkg::OFF_IRQ_SET, 32'hffff_ffff);
    rd(usmis_pkg::OFF_IRQ_STATE);
    chk("mask all", rv, usmis_pkg::IRQ_SRC_MASK);
    wr(usmis_pkg::OFF_IRQ_CLR, 32'hffff_ff7f);
    rd(usmis_pkg::OFF_IRQ_STATE);
    chk("mask one", rv, 32'h0000_0080);
    pulse(2);
    @(negedge CLK);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    @(posedge CLK);
    pulse(0);
    @(negedge CLK);
    chk("irq raised", {31'h0, IRQ}, 32'h1);
    @(posedge CLK);
    cmd(usmis_pkg::CMD_CLR_FLAGS);
    @(negedge CLK);
    chk("irq cleared", {31'h0, IRQ}, 32'h0);
    @(posedge CLK);
    $display("test mask done");
    for (int i = 0; i < 4; i++) begin
      wr(usmis_pkg::OFF_MODE, ((i & 1) << 8) | (i << 6) | (i << 4));
      @(negedge CLK);
      chk("char bits", {28'h0, CHAR_BITS}, 32'h5 + i);
      chk("clock source", {30'h0, BAUD_SOURCE}, i);
      chk("sync framing", {31'h0, SYNC_FRAMING}, i & 1);
      @(posedge CLK);
    end
    wr(usmis_pkg::OFF_MODE, 32'h0000_0c00);
    pulse(0);
    rs();
    cb("multidrop err", 7, 1'b0);
    RX_PARITY_ONE <= 1'b1;
    pulse(8);
    RX_PARITY_ONE <= 1'b0;
    rs();
    cb("multidrop one", 7, 1'b1);
    wr(usmis_pkg::OFF_MODE, 32'h0001_010e);
    @(negedge CLK);
    chk("spi mst", {SPI_ACTIVE, SPI_PHASE, SYNC_FRAMING, SPI_IDLE_LEVEL}, 32'hd);
    @(posedge CLK);
    wr(usmis_pkg::OFF_MODE, 32'h0000_000f);
    pulse(15);
    chk("spi slave", {SPI_SLAVE, SPI_PHASE}, 32'h2);
    rs();
    cb("underrun", 10, 1'b1);
    $display("test mode done");
    CTS_PIN <= 1'b1;
    DMA_BUF_FULL <= 1'b1;
    repeat (4) @(posedge CLK);
    rs();
    chk("cts and dma", rv & 32'h0088_1000, 32'h0088_1000);
    DMA_BUF_FULL <= 1'b0;
    rs();
    chk("cts read clear", rv & 32'h0088_1000, 32'h0080_0000);
    cmd(usmis_pkg::CMD_RX_ON);
    RX_CHAR <= 9'h1a5;
    pulse(14);
    rs();
    cb("char ready", 0, 1'b1);
    rd(usmis_pkg::OFF_RX_HOLD);
    chk("char", rv, 32'h0000_01a5);
    rs();
    cb("char read", 0, 1'b0);
    RX_BUSY <= 1'b1;
    cmd(usmis_pkg::CMD_RX_OFF);
    RX_BUSY <= 1'b0;
    cmd(usmis_pkg::CMD_RX_ON);
    rs();
    cb("rx resumed", 0, 1'b1);
    pulse(13);
    rs();
    cb("timeout zero limit", 8, 1'b0);
    wr(usmis_pkg::OFF_IDLE_LIMIT, 32'h0000_0005);
    pulse(13);
    rs();
    cb("timeout", 8, 1'b1);
    cmd(usmis_pkg::CMD_TO_RESTART);
    rs();
    cb("timeout restart", 8, 1'b0);
    $display("test levels done");
    stall <= 4'hf;
    cmd(usmis_pkg::CMD_TX_ON);
    rs();
    chk("tx idle", rv & 32'h202, 32'h202);
    wr(usmis_pkg::OFF_TX_HOLD, 32'h0000_0055);
    chk("tx char", {23'h0, TX_CHAR}, 32'h55);
    rs();
    chk("tx held", rv & 32'h202, 32'h0);
    repeat (30) @(posedge CLK);
    rs();
    chk("tx drained", rv & 32'h202, 32'h202);
    stall <= 4'h0;
    wr(usmis_pkg::OFF_TX_HOLD, 32'h0000_00aa);
    repeat (2) @(posedge CLK);
    rs();
    cb("tx shifting", 9, 1'b0);
    cmd(usmis_pkg::CMD_BRK_BEGIN);
    rs();
    chk("break", {rv[1], BREAK_REQ}, 32'h1);
    BREAK_STARTED <= 1'b1;
    @(posedge CLK);
    BREAK_STARTED <= 1'b0;
    rs();
    cb("break started", 1, 1'b1);
    rd(8'h40);
    chk("unmapped", {rr, rv[29:0]}, {usmis_pkg::RESP_SLVERR, 30'h0});
    wr(8'h40, 32'h0);
    chk("unmapped write", {30'h0, rr}, {30'h0, usmis_pkg::RESP_SLVERR});
    $display("test transmit done");
    complete_run();
  end
endmodule
`default_nettype wire
